// ---- include/dcc_pkg.sv ----
/*
  constants, field layouts and state type of the dual comparator control block.
  assumes a plain register port with 8-bit data and read data one cycle after the read strobe.
*/
`default_nettype none
package dcc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_FLAG  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_IEN   = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_PORT  = 4'h4;
  // enable register bits
  localparam int IEN_CMP  = 0;
  localparam int IEN_PERI = 1;
  localparam int IEN_GLOB = 2;
  localparam logic [2:0] MODE_OFF      = 3'h7;
  localparam logic [2:0] MODE_FOUR_MUX = 3'h6;
  localparam logic [2:0] MODE_OUT_BOTH = 3'h3;
  localparam logic [2:0] MODE_OUT_B    = 3'h5;
  localparam logic [2:0] PIN_RA0 = 3'h0;
  localparam logic [2:0] PIN_RA1 = 3'h1;
  localparam logic [2:0] PIN_RA2 = 3'h2;
  localparam logic [2:0] PIN_RA3 = 3'h3;
  localparam logic [3:0] PCFG_ALL_ANALOG_LIMIT = 4'he;

  typedef struct packed {
    logic             cmp_b_invert;
    logic             cmp_a_invert;
    logic             input_switch_sel;
    logic [2:0]       cmp_config_sel;
  } dcc_ctrl_t;

  localparam dcc_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, MODE_OFF};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } dcc_bus_t;

  // index 1 is comparator b, index 0 comparator a
  typedef struct packed {
    logic [1:0] power;
    logic [1:0] pos_is_ref;
    logic [2:0] a_neg_pin;
    logic [2:0] a_pos_pin;
    logic [2:0] b_neg_pin;
    logic [2:0] b_pos_pin;
  } dcc_route_t;

  typedef struct packed {
    dcc_ctrl_t         ctrl;
    logic [1:0]        sync1;
    logic [1:0]        sync2;
    logic [1:0]        copy;
    logic              flag;
    logic [2:0]        ien;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              wake;
    dcc_route_t        route;
    logic [1:0]        pin_out;
    logic [1:0]        pin_oe;
  } dcc_state_t;

  localparam dcc_route_t ROUTE_RESET = '{2'b00, 2'b00, PIN_RA0, PIN_RA3, PIN_RA1, PIN_RA2};
  localparam dcc_state_t STATE_RESET = '{CTRL_RESET, 2'b00, 2'b00, 2'b00, 1'b0, 3'h0, 8'h00,
                                         1'b0, 1'b0, ROUTE_RESET, 2'b00, 2'b00};
endpackage
`default_nettype wire

// ---- logic/dcc_top.sv ----
/*
  dual comparator control: control register, input routing, pin output mux,
  change flag with interrupt gating, port read with analog masking.
  assumes the comparator cores deliver one result bit each, asynchronous to ref_clk_i.
*/
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcc_top #(
  parameter int PORT_W = 8
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      ce_i,
  input  wire dcc_pkg::dcc_bus_t         bus_i,
  output var  logic [dcc_pkg::DATA_W-1:0] rdata_o,
  input  wire logic [1:0]                cmp_raw_i,
  input  wire logic [PORT_W-1:0]         porta_direction_i,
  input  wire logic [PORT_W-1:0]         porta_pin_i,
  input  wire logic [3:0]                analog_pin_cfg_i,
  input  wire logic                      sleep_i,
  output var  dcc_pkg::dcc_route_t       route_o,
  output var  logic [1:0]                pin_out_o,
  output var  logic [1:0]                pin_oe_o,
  output var  logic                      irq_o,
  output var  logic                      wake_o
);
  import dcc_pkg::*;

  initial begin
    if (PORT_W < 6 || PORT_W > DATA_W) begin
      $error("dcc_top: PORT_W must be 6 to 8");
    end
  end

  dcc_state_t s;
  dcc_state_t next_s;
  dcc_route_t route_now;
  logic [1:0] live;
  logic [1:0] out_en;
  logic       ctrl_hit;

  // routing of analog inputs per mode
  function automatic dcc_route_t route_of(input logic [2:0] mode, input logic sw);
    dcc_route_t r;
    r = '{2'b11, 2'b00, PIN_RA0, PIN_RA3, PIN_RA1, PIN_RA2};
    unique case (mode)
      MODE_OFF: begin
        r.power = 2'b00;
      end
      MODE_OUT_B: begin
        r.power = 2'b10;
      end
      MODE_FOUR_MUX: begin
        r.pos_is_ref = 2'b11;
        r.a_neg_pin  = sw ? PIN_RA3 : PIN_RA0;
        r.b_neg_pin  = sw ? PIN_RA2 : PIN_RA1;
      end
      default: begin
        r.power = 2'b11;
      end
    endcase
    return r;
  endfunction

  // pins taken as analog by the pin configuration: ra0..ra3 and ra5
  function automatic logic [PORT_W-1:0] analog_mask(input logic [3:0] cfg);
    logic [PORT_W-1:0] m;
    m = '0;
    for (int k = 0; k < 5; k++) begin
      if (cfg <= PCFG_ALL_ANALOG_LIMIT - 4'(k)) begin
        m[(k == 4) ? 5 : k] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic [1:0] polar(input logic [1:0] v, input dcc_ctrl_t c, input logic [1:0] pwr);
    return (v ^ {c.cmp_b_invert, c.cmp_a_invert}) & pwr;
  endfunction

  always_comb begin
    next_s    = s;
    route_now = route_of(s.ctrl.cmp_config_sel, s.ctrl.input_switch_sel);
    live      = polar(s.sync2, s.ctrl, route_now.power);
    ctrl_hit  = (bus_i.wr || bus_i.rd) && bus_i.addr == OFF_CTRL;
    out_en    = 2'b00;

    next_s.sync1 = cmp_raw_i;
    next_s.sync2 = s.sync1;

    if (bus_i.wr) begin
      unique case (bus_i.addr)
        OFF_CTRL: begin
          next_s.ctrl = dcc_ctrl_t'(bus_i.wdata[5:0]);
        end
        OFF_FLAG: begin
          next_s.flag = bus_i.wdata[0];
        end
        OFF_CLEAR: begin
          if (bus_i.wdata[0]) begin
            next_s.flag = 1'b0;
          end
        end
        OFF_IEN: begin
          next_s.ien = bus_i.wdata[2:0];
        end
        default: begin
          next_s.ien = s.ien;
        end
      endcase
    end

    // access ends the mismatch and, in that cycle, a change may go unflagged
    if (ctrl_hit) begin
      next_s.copy = live;
    end else if (live != s.copy) begin
      next_s.flag = 1'b1;
    end

    next_s.rdata = '0;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        OFF_CTRL:  next_s.rdata = {live, s.ctrl};
        OFF_FLAG:  next_s.rdata = {7'h00, s.flag};
        OFF_IEN:   next_s.rdata = {5'h00, s.ien};
        OFF_PORT:  next_s.rdata = DATA_W'(porta_pin_i & ~analog_mask(analog_pin_cfg_i));
        default:   next_s.rdata = '0;
      endcase
    end

    next_s.irq  = next_s.flag && next_s.ien[IEN_CMP] && next_s.ien[IEN_PERI]
                  && next_s.ien[IEN_GLOB];
    // sleep changes nothing else; comparators keep running
    next_s.wake = sleep_i && next_s.flag && next_s.ien[IEN_CMP];

    next_s.route = route_of(next_s.ctrl.cmp_config_sel, next_s.ctrl.input_switch_sel);

    if (s.ctrl.cmp_config_sel == MODE_OUT_BOTH) begin
      out_en = 2'b11;
    end else if (s.ctrl.cmp_config_sel == MODE_OUT_B) begin
      out_en = 2'b10;
    end
    // raw result, one flop only, bypassing the synchroniser
    next_s.pin_out = polar(cmp_raw_i, s.ctrl, route_now.power) & out_en;
    next_s.pin_oe  = out_en & ~porta_direction_i[5:4];
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      s <= STATE_RESET;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign rdata_o   = s.rdata;
  assign route_o   = s.route;
  assign pin_out_o = s.pin_out;
  assign pin_oe_o  = s.pin_oe;
  assign irq_o     = s.irq;
  assign wake_o    = s.wake;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_result_polarity: assert property (
    ce_i && bus_i.rd && bus_i.addr == OFF_CTRL |=> rdata_o[7:6] == $past(live))
    else $error("result bits wrong polarity");

  chk_ctrl_write: assert property (
    ce_i && bus_i.wr && bus_i.addr == OFF_CTRL |=> DATA_W'(s.ctrl) == ($past(bus_i.wdata) & 8'h3f))
    else $error("control write not stored as expected");

  chk_ref_mode: assert property (
    ce_i |=> route_o.pos_is_ref == (($past(next_s.ctrl.cmp_config_sel) == MODE_FOUR_MUX) ? 2'b11 : 2'b00))
    else $error("internal reference routed in wrong mode");

  chk_neg_switch: assert property (
    route_o.pos_is_ref == 2'b11 |-> route_o.a_neg_pin == (s.ctrl.input_switch_sel ? PIN_RA3 : PIN_RA0)
                                 && route_o.b_neg_pin == (s.ctrl.input_switch_sel ? PIN_RA2 : PIN_RA1))
    else $error("negative input switch wrong");

  chk_pin_enable: assert property (
    pin_oe_o != 2'b00 |-> (pin_oe_o & $past(porta_direction_i[5:4])) == 2'b00)
    else $error("pin driven while direction is input");

  chk_flag_set: assert property (
    ce_i && !ctrl_hit && live != s.copy |=> s.flag)
    else $error("mismatch did not set flag");

  chk_flag_soft: assert property (
    ce_i && bus_i.wr && bus_i.addr == OFF_FLAG && bus_i.wdata[0] |=> s.flag)
    else $error("software set of flag lost");

  chk_irq_gate: assert property (
    irq_o |-> s.flag && s.ien == 3'h7)
    else $error("interrupt without all enables");

  chk_reset_value: assert property (
    disable iff (1'b0) !resetn_i |=> s.ctrl == CTRL_RESET && route_o.power == 2'b00)
    else $error("control register reset state wrong");

  chk_port_analog: assert property (
    ce_i && bus_i.rd && bus_i.addr == OFF_PORT |=>
      (rdata_o & DATA_W'($past(analog_mask(analog_pin_cfg_i)))) == 8'h00)
    else $error("analog pin read as nonzero");

  // read data stand for one cycle only and are zero otherwise
  chk_rdata_idle: assert property (
    ce_i && !bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");

  chk_ce_freeze: assert property (
    !ce_i |=> s == $past(s))
    else $error("state moved while clock enable low");

  chk_wake_gate: assert property (
    wake_o |-> s.flag && s.ien[IEN_CMP])
    else $error("wake without flag and enable");

  chk_pin_mode: assert property (
    pin_oe_o[0] |-> $past(s.ctrl.cmp_config_sel) == MODE_OUT_BOTH)
    else $error("pin a driven outside its output mode");

  chk_flag_clear: assert property (
    ce_i && bus_i.wr && bus_i.addr == OFF_CLEAR && bus_i.wdata[0] && live == s.copy |=> !s.flag)
    else $error("flag clear lost");

  cov_wake:       cover property ($rose(wake_o));
  cov_flag_rise:  cover property (!s.flag ##1 s.flag);
  cov_irq:        cover property ($rose(irq_o));
  cov_pin_out:    cover property (pin_oe_o == 2'b11 && pin_out_o != 2'b00);
  cov_switch:     cover property (route_o.pos_is_ref == 2'b11 && s.ctrl.input_switch_sel);
endmodule // dcc_top
`default_nettype wire

// ---- bench/dcc_cmp_model.sv ----
/*
  behavioural comparator cores and port pin levels for the dual comparator block.
  assumes one 8-bit analog level per port pin and a route taken from the block's route output.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_cmp_model
  import dcc_pkg::*;
(
  input  wire logic [7:0][7:0]     lvl_i,
  input  wire logic [7:0]          vref_i,
  input  wire dcc_pkg::dcc_route_t route_i,
  output var  logic [1:0]          cmp_raw_o,
  output var  logic [7:0]          porta_pin_o
);
  import dcc_pkg::*;
  always_comb begin
    // a powered-off core gives a low output
    cmp_raw_o[0] = route_i.power[0] &
      ((route_i.pos_is_ref[0] ? vref_i : lvl_i[route_i.a_pos_pin]) > lvl_i[route_i.a_neg_pin]);
    cmp_raw_o[1] = route_i.power[1] &
      ((route_i.pos_is_ref[1] ? vref_i : lvl_i[route_i.b_pos_pin]) > lvl_i[route_i.b_neg_pin]);
    for (int k = 0; k < 8; k++) begin
      porta_pin_o[k] = lvl_i[k][7];
    end
  end
endmodule // dcc_cmp_model
`default_nettype wire

// ---- bench/testbench.sv ----
/*
  self-checking bench for the dual comparator control block.
  assumes the comparator model closes the loop from route to raw results.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dcc_pkg::*;
  logic            ref_clk_i = 1'b0;
  logic            resetn_i  = 1'b0;
  dcc_bus_t        bus       = '0;
  logic [7:0]      rdata, rd_val;
  logic [7:0]      pdir      = 8'hff;
  logic [7:0]      vref      = 8'h80;
  logic [3:0]      acfg      = 4'hf;
  logic            sleep     = 1'b0;
  logic            ce        = 1'b1;
  logic [7:0][7:0] lvl       = '0;
  logic [1:0]      raw, pin_out, pin_oe;
  logic [7:0]      pins;
  dcc_route_t      route;
  logic            irq, wake;
  int              error_cnt = 0;
  int              checks_done = 0;

  always #2 ref_clk_i = ~ref_clk_i;

  dcc_top u_dcc_top (
    .ref_clk_i         (ref_clk_i),
    .resetn_i          (resetn_i),
    .ce_i              (ce),
    .bus_i             (bus),
    .rdata_o           (rdata),
    .cmp_raw_i         (raw),
    .porta_direction_i (pdir),
    .porta_pin_i       (pins),
    .analog_pin_cfg_i  (acfg),
    .sleep_i           (sleep),
    .route_o           (route),
    .pin_out_o         (pin_out),
    .pin_oe_o          (pin_oe),
    .irq_o             (irq),
    .wake_o            (wake)
  );

  dcc_cmp_model u_dcc_cmp_model (
    .lvl_i       (lvl),
    .vref_i      (vref),
    .route_i     (route),
    .cmp_raw_o   (raw),
    .porta_pin_o (pins)
  );

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    #1 rd_val = rdata;
    chk(exp, rd_val);
  endtask

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rchk(OFF_CTRL, 8'h07);
    rchk(OFF_FLAG, 8'h00);
    rchk(4'hf, 8'h00);
    wr(OFF_CTRL, 8'hc7);
    rchk(OFF_CTRL, 8'h07);
    lvl <= {32'h0, 8'h96, 8'h64, 8'h96, 8'h64};
    wr(OFF_CTRL, 8'h00);
    repeat (4) @(posedge ref_clk_i);
    rchk(OFF_CTRL, 8'h40);
    wr(OFF_CTRL, 8'h10);
    repeat (4) @(posedge ref_clk_i);
    rchk(OFF_CTRL, 8'h10);
    wr(OFF_FLAG, 8'h00);
    rchk(OFF_FLAG, 8'h00);
    lvl[3] <= 8'h32;
    repeat (4) @(posedge ref_clk_i);
    rchk(OFF_FLAG, 8'h01);
    chk(8'h00, {7'h0, irq});
    wr(OFF_IEN, 8'h03);
    repeat (2) @(posedge ref_clk_i);
    #1 chk(8'h00, {7'h0, irq});
    wr(OFF_IEN, 8'h07);
    repeat (2) @(posedge ref_clk_i);
    #1 chk(8'h01, {7'h0, irq});
    rchk(OFF_CTRL, 8'h50);
    wr(OFF_CLEAR, 8'h01);
    rchk(OFF_FLAG, 8'h00);
    wr(OFF_FLAG, 8'h01);
    rchk(OFF_FLAG, 8'h01);
    wr(OFF_IEN, 8'h01);
    wr(OFF_FLAG, 8'h00);
    sleep <= 1'b1;
    lvl[3] <= 8'h96;
    repeat (5) @(posedge ref_clk_i);
    #1 chk(8'h01, {7'h0, wake});
    chk(8'h00, {7'h0, irq});
    @(posedge ref_clk_i);
    sleep <= 1'b0;
    rchk(OFF_CTRL, 8'h10);
    wr(OFF_IEN, 8'h00);
    wr(OFF_CTRL, 8'h06);
    repeat (4) @(posedge ref_clk_i);
    rchk(OFF_CTRL, 8'h46);
    wr(OFF_CTRL, 8'h0e);
    repeat (4) @(posedge ref_clk_i);
    rchk(OFF_CTRL, 8'h8e);
    for (int m = 0; m < 8; m++) begin
      wr(OFF_CTRL, 8'(m));
      repeat (2) @(posedge ref_clk_i);
      #1 chk((m == 6) ? 8'h03 : 8'h00, {6'h0, route.pos_is_ref});
    end
    chk(8'h00, {6'h0, route.power});
    pdir <= 8'h00;
    wr(OFF_CTRL, 8'h03);
    repeat (4) @(posedge ref_clk_i);
    #1 chk(8'h07, {4'h0, pin_out, pin_oe});
    @(posedge ref_clk_i);
    pdir <= 8'h10;
    repeat (2) @(posedge ref_clk_i);
    #1 chk(8'h06, {4'h0, pin_out, pin_oe});
    wr(OFF_CTRL, 8'h33);
    repeat (3) @(posedge ref_clk_i);
    #1 chk(8'h0a, {4'h0, pin_out, pin_oe});
    @(posedge ref_clk_i);
    lvl <= '1;
    acfg <= 4'h0;
    rchk(OFF_PORT, 8'hd0);
    @(posedge ref_clk_i);
    acfg <= 4'hf;
    rchk(OFF_PORT, 8'hff);
    // a write with the clock enable low must leave the enables as they are
    @(posedge ref_clk_i);
    ce <= 1'b0;
    wr(OFF_IEN, 8'h06);
    ce <= 1'b1;
    rchk(OFF_IEN, 8'h00);
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rchk(OFF_CTRL, 8'h07);
    rchk(OFF_FLAG, 8'h00);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
